// ---- rtl/ascs_pkg.sv ----
/*
 * Constants, types and decode helpers of the sample/conversion sequencer.
 * Assumes a 125 MHz system clock and a bus clock from the serial master.
 */
package ascs_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_MHZ          = 125;
   localparam int INT_CONV_NS      = 100;
   localparam int INT_CONV_CYC     = (INT_CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int SAR_BITS         = 10;

   // ==========================================================
   // Bus clock edge numbers within a frame
   // ==========================================================
   localparam logic [4:0] ADDR_LAST_EDGE = 5'h08;
   localparam logic [4:0] ACK_EDGE       = 5'h09;
   localparam logic [4:0] EXT_HOLD_EDGE  = 5'h0B;
   localparam logic [6:0] SLAVE_ADDR     = 7'h2A;  // Arbitrary value

   // ==========================================================
   // Register map
   // ==========================================================
   localparam int          ADDR_W         = 4;
   localparam logic [3:0]  REG_CTRL       = 4'h0;
   localparam logic [3:0]  REG_STATUS     = 4'h4;
   localparam int          CTRL_EXT_BIT   = 0;
   localparam int          CTRL_PAIR_BIT  = 1;
   localparam int          CTRL_CHAN_LSB  = 2;
   localparam int          CTRL_REF_LSB   = 6;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0002;
   localparam int          STAT_TH_LSB    = 0;
   localparam int          STAT_MODE_BIT  = 2;
   localparam int          STAT_RES_LSB   = 16;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {TH_IDLE, TH_TRACK, TH_HOLD} ascs_th_t;
   typedef enum logic [1:0] {PIN_ANALOG, PIN_REF_IN, PIN_REF_OUT} ascs_pin_t;

   typedef struct packed {
      logic [2:0] refSel;
      logic [3:0] chanSel;
      logic       inputPairingSelect;
      logic       extClkMode;
   } ascs_ctrl_t;

   typedef struct packed {
      logic [3:0] posSel;
      logic [3:0] negSel;
      logic       negIsGnd;
   } ascs_mux_t;

   // ==========================================================
   // Decode helpers
   // ==========================================================
   function automatic ascs_mux_t muxDecode(input logic pairSel, input logic [3:0] cs);
      ascs_mux_t m;
      m.posSel   = cs;
      m.negSel   = 4'h0;
      m.negIsGnd = 1'b1;
      if (!pairSel) begin
         m.posSel   = {cs[3:1], cs[0]};
         m.negSel   = {cs[3:1], ~cs[0]};
         m.negIsGnd = 1'b0;
      end
      return m;
   endfunction : muxDecode

   function automatic ascs_pin_t pinDecode(input logic [2:0] refSel);
      ascs_pin_t p;
      unique case (refSel[2:1])
         2'b01:   p = PIN_REF_IN;
         2'b11:   p = PIN_REF_OUT;
         default: p = PIN_ANALOG;
      endcase
      return p;
   endfunction : pinDecode

endpackage : ascs_pkg

// ---- rtl/ascs_sync.sv ----
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none

module ascs_sync
   import ascs_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic async,
   output var  logic q
);

   logic s1_r;
   logic s2_r;
   logic s3_r;

   // ==========================================================
   // Stages and agreement
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         q    <= 1'b0;
      end else begin
         s1_r <= async;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            q <= s3_r;
         end
      end
   end

endmodule : ascs_sync

`default_nettype wire

// ---- rtl/ascs_sar.sv ----
/*
 * Successive-approximation step engine, one bit per step.
 * Assumes compIn is high while the input lies at or above the trial code.
 */
`timescale 1ns/100ps
`default_nettype none

module ascs_sar
   import ascs_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                start,
   input  wire logic                step,
   input  wire logic                compIn,
   output var  logic                busy,
   output var  logic                done,
   output var  logic [SAR_BITS-1:0] trial,
   output var  logic [SAR_BITS-1:0] result
);

   logic [3:0] bitIdx_r;

   // ==========================================================
   // Bit trials
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy     <= 1'b0;
         done     <= 1'b0;
         trial    <= '0;
         result   <= '0;
         bitIdx_r <= 4'h0;
      end else begin
         done <= 1'b0;
         if (start) begin
            busy     <= 1'b1;
            trial    <= {1'b1, {(SAR_BITS-1){1'b0}}};
            bitIdx_r <= 4'(SAR_BITS - 1);
         end else if (busy && step) begin
            trial[bitIdx_r] <= compIn;
            if (bitIdx_r == 4'h0) begin
               busy   <= 1'b0;
               done   <= 1'b1;
               result <= {trial[SAR_BITS-1:1], compIn};
            end else begin
               trial[bitIdx_r - 4'h1] <= 1'b1;
               bitIdx_r               <= bitIdx_r - 4'h1;
            end
         end
      end
   end

endmodule : ascs_sar

`default_nettype wire

// ---- rtl/ascs_sequencer.sv ----
/*
 * Track/hold and conversion sequencer of a multichannel SAR converter.
 * Assumes a two-wire bus master that drives sclIn and tolerates clock
 * stretching; the bus clock also clocks the external-mode conversion.
 */
// Behaviour
// - In internal-clock mode tracking starts on the eighth rising bus clock edge of the address.
// - In internal-clock mode hold starts on the falling edge of the ninth, acknowledge, pulse.
// - In internal-clock mode conversion runs on the own clock while the bus clock is held low.
// - In external-clock mode tracking starts on the rising edge of a read bit after a matching address.
// - In external-clock mode hold starts on the second rising edge of the first result byte.
// - After hold the conversion completes over ten conversion clock cycles.
// - With pairing select 1 the channel chosen by the select field is converted against ground.
// - With pairing select 0 the difference of the selected plus and minus inputs is converted.
// - The reference setting decides if the shared pin is analog input, reference input or output.
// - In external-clock mode the bus clock is the conversion clock.
`timescale 1ns/100ps
`default_nettype none

module ascs_sequencer
   import ascs_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                sclClk,
   input  wire logic                sclIn,
   output var  logic                sclOut,
   output var  logic                sclOe,
   input  wire logic                sdaIn,
   output var  logic                sdaOut,
   output var  logic                sdaOe,
   input  wire logic                compIn,
   output var  logic                trackEn,
   output var  logic                holdEn,
   output var  logic [SAR_BITS-1:0] intDacTrial,
   output var  logic [SAR_BITS-1:0] extDacTrial,
   output var  ascs_mux_t           muxSel,
   output var  ascs_pin_t           sharedPinMode,
   input  wire logic [ADDR_W-1:0]   regAddr,
   input  wire logic [31:0]         regWrData,
   input  wire logic                regWrEn,
   input  wire logic                regRdEn,
   output var  logic [31:0]         regRdData
);

   // ==========================================================
   // Declarations
   // ==========================================================
   ascs_ctrl_t          ctrl_r;
   ascs_th_t            thState_r;
   logic                sclS;
   logic                sdaS;
   logic                sclD_r;
   logic                sdaD_r;
   logic                sclRise;
   logic                sclFall;
   logic                startCond;
   logic                stopCond;
   logic [4:0]          edgeCnt_r;
   logic [4:0]          edgeCnt_nxt;
   logic [7:0]          addrSh_r;
   logic                addrHit;
   logic                matched_r;
   logic                convExt_r;
   logic                intStart_r;
   logic [7:0]          divCnt_r;
   logic                intTick;
   logic                intBusy;
   logic                intDone;
   logic [SAR_BITS-1:0] intResult;
   logic                holdTgl_r;
   logic                holdTglS;
   logic                holdSeen_r;
   logic                extStart;
   logic                extBusy;
   logic                extDone;
   logic [SAR_BITS-1:0] extResult;
   logic                doneTgl_r;
   logic                doneTglS;
   logic                doneSeen_r;
   logic                extDoneSys;
   logic [SAR_BITS-1:0] result_r;
   logic                stretch_r;

   // ==========================================================
   // Bus pin synchronisers
   // ==========================================================
   ascs_sync uSclSync (
      .clk   (clk),
      .rst_n (rst_n),
      .async (sclIn),
      .q     (sclS)
   );

   ascs_sync uSdaSync (
      .clk   (clk),
      .rst_n (rst_n),
      .async (sdaIn),
      .q     (sdaS)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclD_r <= 1'b1;
         sdaD_r <= 1'b1;
      end else begin
         sclD_r <= sclS;
         sdaD_r <= sdaS;
      end
   end

   assign sclRise   = sclS & ~sclD_r;
   assign sclFall   = ~sclS & sclD_r;
   assign startCond = sclS & sclD_r & sdaD_r & ~sdaS;
   assign stopCond  = sclS & sclD_r & ~sdaD_r & sdaS;

   // ==========================================================
   // Frame edge counting and address capture
   // ==========================================================
   assign edgeCnt_nxt = (edgeCnt_r == 5'h1F) ? edgeCnt_r : edgeCnt_r + 5'h01;
   assign addrHit     = (addrSh_r[6:0] == SLAVE_ADDR);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edgeCnt_r <= 5'h00;
         addrSh_r  <= 8'h00;
      end else if (startCond || stopCond) begin
         edgeCnt_r <= 5'h00;
         addrSh_r  <= 8'h00;
      end else if (sclRise) begin
         edgeCnt_r <= edgeCnt_nxt;
         if (edgeCnt_r < ADDR_LAST_EDGE) begin
            addrSh_r <= {addrSh_r[6:0], sdaS};
         end
      end
   end

   // ==========================================================
   // Address acknowledge
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         matched_r <= 1'b0;
         sdaOe     <= 1'b0;
      end else if (startCond || stopCond) begin
         matched_r <= 1'b0;
         sdaOe     <= 1'b0;
      end else begin
         if (sclRise && (edgeCnt_nxt == ADDR_LAST_EDGE)) begin
            matched_r <= addrHit;
         end
         if (sclFall && (edgeCnt_r == ADDR_LAST_EDGE) && matched_r) begin
            sdaOe <= 1'b1;
         end else if (sclFall && (edgeCnt_r == ACK_EDGE)) begin
            sdaOe <= 1'b0;
         end
      end
   end

   assign sdaOut = 1'b0;

   // ==========================================================
   // Track/hold sequencing
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thState_r  <= TH_IDLE;
         convExt_r  <= 1'b0;
         intStart_r <= 1'b0;
         holdTgl_r  <= 1'b0;
      end else begin
         intStart_r <= 1'b0;
         unique case (thState_r)
            TH_IDLE: begin
               if (sclRise && (edgeCnt_nxt == ADDR_LAST_EDGE) && addrHit && sdaS) begin
                  thState_r <= TH_TRACK;
                  convExt_r <= ctrl_r.extClkMode;
               end
            end
            TH_TRACK: begin
               if (startCond || stopCond) begin
                  thState_r <= TH_IDLE;
               end else if (!convExt_r && sclFall && (edgeCnt_r == ACK_EDGE)) begin
                  thState_r  <= TH_HOLD;
                  intStart_r <= 1'b1;
               end else if (convExt_r && sclRise && (edgeCnt_nxt == EXT_HOLD_EDGE)) begin
                  thState_r <= TH_HOLD;
                  holdTgl_r <= ~holdTgl_r;
               end
            end
            TH_HOLD: begin
               if ((!convExt_r && intDone) || (convExt_r && extDoneSys)) begin
                  thState_r <= TH_IDLE;
               end
            end
         endcase
      end
   end

   assign trackEn = (thState_r == TH_TRACK);
   assign holdEn  = (thState_r == TH_HOLD);

   // ==========================================================
   // Internal conversion clock and clock stretching
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_r <= 8'h00;
      end else if (!intBusy || intTick) begin
         divCnt_r <= 8'h00;
      end else begin
         divCnt_r <= divCnt_r + 8'h01;
      end
   end

   assign intTick = (divCnt_r == 8'(INT_CONV_CYC - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stretch_r <= 1'b0;
      end else begin
         stretch_r <= (intStart_r || intBusy) && !intDone;
      end
   end

   assign sclOut = 1'b0;
   assign sclOe  = stretch_r;

   ascs_sar uIntSar (
      .clk    (clk),
      .rst_n  (rst_n),
      .start  (intStart_r),
      .step   (intTick),
      .compIn (compIn),
      .busy   (intBusy),
      .done   (intDone),
      .trial  (intDacTrial),
      .result (intResult)
   );

   // ==========================================================
   // External conversion on the bus clock
   // ==========================================================
   ascs_sync uHoldSync (
      .clk   (sclClk),
      .rst_n (rst_n),
      .async (holdTgl_r),
      .q     (holdTglS)
   );

   always_ff @(posedge sclClk or negedge rst_n) begin
      if (!rst_n) begin
         holdSeen_r <= 1'b0;
      end else begin
         holdSeen_r <= holdTglS;
      end
   end

   assign extStart = holdTglS ^ holdSeen_r;

   ascs_sar uExtSar (
      .clk    (sclClk),
      .rst_n  (rst_n),
      .start  (extStart),
      .step   (1'b1),
      .compIn (compIn),
      .busy   (extBusy),
      .done   (extDone),
      .trial  (extDacTrial),
      .result (extResult)
   );

   always_ff @(posedge sclClk or negedge rst_n) begin
      if (!rst_n) begin
         doneTgl_r <= 1'b0;
      end else if (extDone) begin
         doneTgl_r <= ~doneTgl_r;
      end
   end

   ascs_sync uDoneSync (
      .clk   (clk),
      .rst_n (rst_n),
      .async (doneTgl_r),
      .q     (doneTglS)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         doneSeen_r <= 1'b0;
      end else begin
         doneSeen_r <= doneTglS;
      end
   end

   assign extDoneSys = doneTglS ^ doneSeen_r;

   // ==========================================================
   // Result capture
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= '0;
      end else if (intDone) begin
         result_r <= intResult;
      end else if (extDoneSys) begin
         result_r <= extResult;
      end
   end

   // ==========================================================
   // Input mux and shared pin control
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         muxSel        <= muxDecode(CTRL_RESET[CTRL_PAIR_BIT], 4'h0);
         sharedPinMode <= PIN_ANALOG;
      end else begin
         muxSel        <= muxDecode(ctrl_r.inputPairingSelect, ctrl_r.chanSel);
         sharedPinMode <= pinDecode(ctrl_r.refSel);
      end
   end

   // ==========================================================
   // Register port
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r.extClkMode         <= CTRL_RESET[CTRL_EXT_BIT];
         ctrl_r.inputPairingSelect <= CTRL_RESET[CTRL_PAIR_BIT];
         ctrl_r.chanSel            <= CTRL_RESET[CTRL_CHAN_LSB +: 4];
         ctrl_r.refSel             <= CTRL_RESET[CTRL_REF_LSB +: 3];
      end else if (regWrEn && (regAddr == REG_CTRL)) begin
         ctrl_r.extClkMode         <= regWrData[CTRL_EXT_BIT];
         ctrl_r.inputPairingSelect <= regWrData[CTRL_PAIR_BIT];
         ctrl_r.chanSel            <= regWrData[CTRL_CHAN_LSB +: 4];
         ctrl_r.refSel             <= regWrData[CTRL_REF_LSB +: 3];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 32'h0000_0000;
      end else begin
         regRdData <= 32'h0000_0000;
         if (regRdEn && (regAddr == REG_CTRL)) begin
            regRdData[CTRL_EXT_BIT]        <= ctrl_r.extClkMode;
            regRdData[CTRL_PAIR_BIT]       <= ctrl_r.inputPairingSelect;
            regRdData[CTRL_CHAN_LSB +: 4]  <= ctrl_r.chanSel;
            regRdData[CTRL_REF_LSB +: 3]   <= ctrl_r.refSel;
         end else if (regRdEn && (regAddr == REG_STATUS)) begin
            regRdData[STAT_TH_LSB +: 2]    <= thState_r;
            regRdData[STAT_MODE_BIT]       <= convExt_r;
            regRdData[STAT_RES_LSB +: SAR_BITS] <= result_r;
         end
      end
   end

endmodule : ascs_sequencer

`default_nettype wire

// ---- tb/ascs_sequencer_properties.sv ----
/* Port-level checks of the track/hold sequencer.
   Assumes it is bound to ascs_sequencer and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none

module ascs_sequencer_properties
   import ascs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              sclOe,
   input  wire logic              trackEn,
   input  wire logic              holdEn,
   input  wire ascs_mux_t         muxSel,
   input  wire ascs_pin_t         sharedPinMode,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [31:0]       regWrData,
   input  wire logic              regWrEn
);
   logic       ctrlWr;
   logic [1:0] refHi;
   assign ctrlWr = regWrEn && (regAddr == REG_CTRL);
   assign refHi  = regWrData[CTRL_REF_LSB+1 +: 2];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Track/hold sequence
   // ==========================================================
   property p_holdAfterTrack;
      $rose(holdEn) |-> $past(trackEn);
   endproperty
   a_holdAfterTrack: assert property (p_holdAfterTrack)
      else $error("hold began without tracking");
   property p_stretchInHold;
      sclOe |-> holdEn || $past(holdEn);
   endproperty
   a_stretchInHold: assert property (p_stretchInHold)
      else $error("clock held low outside a conversion");
   property p_stretchMin;
      $rose(sclOe) |-> sclOe [*8];
   endproperty
   a_stretchMin: assert property (p_stretchMin)
      else $error("clock stretch too short");
   property p_convLen;
      $rose(sclOe) |-> ##99 sclOe ##[1:60] !sclOe;
   endproperty
   a_convLen: assert property (p_convLen)
      else $error("internal conversion length off");
   property p_idleAfter;
      $fell(holdEn) |-> !trackEn [*4];
   endproperty
   a_idleAfter: assert property (p_idleAfter)
      else $error("tracking right after conversion");

   // ==========================================================
   // Input pairing and shared pin
   // ==========================================================
   property p_single;
      ctrlWr && regWrData[CTRL_PAIR_BIT] |-> ##2 muxSel.negIsGnd &&
         muxSel.posSel == $past(regWrData[CTRL_CHAN_LSB +: 4], 2);
   endproperty
   a_single: assert property (p_single)
      else $error("single-ended select wrong");
   property p_diff;
      ctrlWr && !regWrData[CTRL_PAIR_BIT] |-> ##2 !muxSel.negIsGnd &&
         muxSel.posSel == $past(regWrData[CTRL_CHAN_LSB +: 4], 2) &&
         muxSel.negSel == {muxSel.posSel[3:1], ~muxSel.posSel[0]};
   endproperty
   a_diff: assert property (p_diff)
      else $error("differential select wrong");
   property p_pin;
      ctrlWr |-> ##2 sharedPinMode == ($past(refHi, 2) == 2'b01 ? PIN_REF_IN :
         $past(refHi, 2) == 2'b11 ? PIN_REF_OUT : PIN_ANALOG);
   endproperty
   a_pin: assert property (p_pin)
      else $error("shared pin mode wrong");
endmodule : ascs_sequencer_properties

bind ascs_sequencer ascs_sequencer_properties chk_u (
   .clk(clk), .rst_n(rst_n), .sclOe(sclOe), .trackEn(trackEn), .holdEn(holdEn),
   .muxSel(muxSel), .sharedPinMode(sharedPinMode), .regAddr(regAddr),
   .regWrData(regWrData), .regWrEn(regWrEn)
);
`default_nettype wire

// ---- tb/ascs_bus_master.sv ----
/* Two-wire bus master model: makes the bus clock and data.
   Assumes pulled-up open-drain wires resolved by the bench. */
`timescale 1ns/100ps
`default_nettype none

module ascs_bus_master (
   input  wire logic sclW,
   input  wire logic sdaW,
   output var  logic sclM,
   output var  logic sdaM
);
   int lowNs   = 30;
   int riseCnt = 0;

   initial begin
      sclM = 1'b1;
      sdaM = 1'b1;
   end

   // One clock pulse; a stretched low is waited out
   task automatic pulse(input logic b, output logic s);
      #10;
      sdaM = b;
      #(lowNs);
      sclM = 1'b1;
      #20;
      for (int i = 0; i < 500 && !sclW; i++) #8;
      riseCnt++;
      #20;
      s    = sdaW;
      sclM = 1'b0;
   endtask : pulse

   // Start, address byte, acknowledge, three bytes, stop
   task automatic frame(input logic [6:0] a, input logic rw, output logic ack);
      logic [7:0] v;
      logic       s;
      #3; // Off the system clock edges
      v       = {a, rw};
      riseCnt = 0;
      sdaM    = 1'b0;
      #40;
      sclM = 1'b0;
      for (int i = 7; i >= 0; i--) pulse(v[i], s);
      pulse(1'b1, s);
      ack = !s;
      for (int i = 0; i < 27; i++) pulse(1'b1, s);
      #10;
      sdaM = 1'b0;
      #30;
      sclM = 1'b1;
      #40;
      sdaM = 1'b1;
      #80;
   endtask : frame
endmodule : ascs_bus_master
`default_nettype wire

// ---- tb/tb.sv ----
/* Self-checking bench of the track/hold sequencer.
   Assumes the bus master model and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none

module tb
   import ascs_pkg::*;
;
   logic                clk = 1'b0, rst_n = 1'b0, sclM, sdaM, sclOe, sdaOe, compIn;
   logic                trackEn, holdEn, regWrEn = 1'b0, regRdEn = 1'b0, sclOut, sdaOut;
   logic [ADDR_W-1:0]   regAddr   = '0;
   logic [31:0]         regWrData = '0, regRdData;
   logic [9:0]          target    = '0, intDacTrial, extDacTrial;
   logic                ext       = 1'b0, stretched;
   ascs_mux_t           muxSel;
   ascs_pin_t           sharedPinMode;
   wire logic           sclW, sdaW;
   int                  num_errors = 0, checks = 0, seed = 45163, trackAt, holdAt;

   assign sclW   = sclM & ~sclOe;
   assign sdaW   = sdaM & ~sdaOe;
   assign compIn = ext ? (target >= extDacTrial) : (target >= intDacTrial);

   always #4 clk = ~clk;
   always @(posedge trackEn) trackAt = master_u.riseCnt;
   always @(posedge holdEn) holdAt = master_u.riseCnt;
   always @(posedge sclOe) stretched = 1'b1;

   ascs_bus_master master_u (.sclW(sclW), .sdaW(sdaW), .sclM(sclM), .sdaM(sdaM));

   ascs_sequencer dut_u (
      .clk(clk), .rst_n(rst_n), .sclClk(sclW), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
      .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .compIn(compIn), .trackEn(trackEn),
      .holdEn(holdEn), .intDacTrial(intDacTrial), .extDacTrial(extDacTrial),
      .muxSel(muxSel), .sharedPinMode(sharedPinMode), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData)
   );

   // ==========================================================
   // Register port and comparison
   // ==========================================================
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1;
      d = regRdData;
   endtask : rd

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      logic [31:0] d, w;
      logic [6:0]  adr;
      logic        rw, ack, go;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(REG_CTRL, d);
      check("ctrl reset", d, CTRL_RESET);
      rd(4'h8, d);
      check("unmapped", d, 32'h0000_0000);
      for (int r = 0; r < 8; r++) begin
         w = ($random(seed) & 32'h0000_003E) | (r << 6);
         wr(REG_CTRL, w);
         @(posedge clk);
         #1;
         check("pos", muxSel.posSel, w[5:2]);
         check("neg", muxSel.negSel, w[1] ? 4'h0 : w[5:2] ^ 4'h1);
         check("gnd", muxSel.negIsGnd, w[1]);
         check("pin", sharedPinMode, r[2:1] == 1 ? PIN_REF_IN :
               r[2:1] == 3 ? PIN_REF_OUT : PIN_ANALOG);
         rd(REG_CTRL, d);
         check("ctrl", d & 32'h0000_01FF, w);
      end
      for (int f = 0; f < 6; f++) begin
         ext            = f[0];
         adr            = (f == 4) ? SLAVE_ADDR ^ 7'h01 : SLAVE_ADDR;
         rw             = (f != 5);
         go             = (f < 4);
         target         = 10'($random(seed));
         wr(REG_CTRL, 32'h0000_0002 | 32'(ext));
         trackAt   = -1;
         holdAt    = -1;
         stretched = 1'b0;
         master_u.frame(adr, rw, ack);
         for (int i = 0; i < 400 && holdEn; i++) @(posedge clk);
         check("ack", ack, f != 4);
         check("pin drive", {sclOut, sdaOut}, 2'b00);
         check("track edge", trackAt, go ? 8 : -1);
         check("hold edge", holdAt, !go ? -1 : ext ? 11 : 9);
         check("stretch", stretched, go && !ext);
         rd(REG_STATUS, d);
         check("state", d[1:0], 2'b00);
         if (go) begin
            check("result", d[25:16], target);
            check("mode", d[2], ext);
         end
      end
      close_out();
   end

   initial begin
      #400_000;
      num_errors++;
      close_out();
   end
endmodule : tb
`default_nettype wire
